// ---- common/lmd_pkg.sv ----
// Constants, register map and drive encodings for the LCD multiplex drive timing block
package lmd_pkg;
	// Clock rates and frame division
	localparam int unsigned CLK_FREQ_HZ   = 125_000_000;        // System clock rate
	localparam int unsigned OSC_FREQ_HZ   = 1970;               // Working clock rate, typical
	localparam int unsigned OSC_HALF_DFLT = CLK_FREQ_HZ / (2 * OSC_FREQ_HZ); // Cycles per half period
	localparam logic [4:0]  FRAME_LAST    = 5'h17;              // Frame is 24 working ticks, 0..23
	localparam int unsigned NUM_SEG       = 60;                 // Segment outputs
	localparam int unsigned NUM_BP        = 4;                  // Backplane outputs
	// Register byte offsets
	localparam logic [7:0]  CTRL_OFS      = 8'h00;              // Drive configuration
	localparam logic [7:0]  STAT_OFS      = 8'h04;              // Timing status
	localparam logic [7:0]  RAM_OFS       = 8'h10;              // First display RAM word
	localparam logic [7:0]  RAM_END       = 8'h2C;              // Last display RAM word
	localparam logic [31:0] RAM_HI_MASK   = 32'h0FFF_FFFF;      // Columns 32..59 in odd words
	// Control fields and reset value: 1:4 multiplex, half bias, display off
	localparam int unsigned CTRL_EN_BIT   = 0;
	localparam int unsigned CTRL_MODE_LSB = 1;
	localparam int unsigned CTRL_HALF_BIT = 3;
	localparam logic [31:0] CTRL_RST      = 32'h0000_000E;
	localparam logic [31:0] CTRL_MASK     = 32'h0000_000F;
	// Status fields
	localparam int unsigned STAT_OSC_BIT  = 8;
	localparam int unsigned STAT_FCNT_LSB = 16;
	// Bus responses
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;
	// Drive level codes, fractions of the LCD supply
	localparam logic [1:0]  LVL_VSS       = 2'h0;
	localparam logic [1:0]  LVL_THIRD     = 2'h1;
	localparam logic [1:0]  LVL_HALF      = 2'h1;
	localparam logic [1:0]  LVL_TWO3      = 2'h2;
	localparam logic [1:0]  LVL_VLCD      = 2'h3;
	// Multiplex drive modes, code plus one is the multiplex ratio
	typedef enum logic [1:0] {LMD_STATIC, LMD_MUX2, LMD_MUX3, LMD_MUX4} lmd_mode_t;
	// Working ticks per backplane slot, two slots per backplane per frame
	function automatic logic [3:0] lmd_slot_len(input lmd_mode_t mode);
		case (mode)
			LMD_STATIC: lmd_slot_len = 4'hC;
			LMD_MUX2:   lmd_slot_len = 4'h6;
			LMD_MUX3:   lmd_slot_len = 4'h4;
			default:    lmd_slot_len = 4'h3;
		endcase
	endfunction
endpackage

// ---- hdl/lmd_drive.sv ----
// LCD multiplex drive timing: clock select, frame divider, cascade sync and drive levels
// Functional notes
// - Drive follows last configured mode-set values
// - Static mode: two levels, one backplane
// - Two backplanes: half or third bias selectable
// - Three backplanes use 1:3 multiplex, third bias
// - Four backplanes use 1:4 multiplex, third bias
// - Half bias also allowed in 1:3, 1:4
// - Level step is supply over one plus a
// - Multiplex ratio equals active backplane count
// - One working clock times all drive logic
// - Strap low: internal oscillator, clock driven out
// - Strap high: clock pin is external input
// - Frame lasts 24 working clock ticks
// - Cascaded frames aligned by active-low sync
// - Display register holds data during frame
// - Segments from phase and display register bit
// - Reset: 1:4 half bias, display off, VLCD
// - Unused backplanes mirror active ones per mode
// - One drives on, row k with backplane k
//
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
module lmd_drive
	import lmd_pkg::*;
#(
	parameter int unsigned OSC_HALF_CYC = OSC_HALF_DFLT      // Internal oscillator half period
) (
	// Clock and reset
	input  wire logic           clock_i,
	input  wire logic           arst_n_i,
	// AXI4-Lite write address and data
	input  wire logic [7:0]     s_axi_awaddr_i,
	input  wire logic           s_axi_awvalid_i,
	output logic                s_axi_awready_o,
	input  wire logic [31:0]    s_axi_wdata_i,
	input  wire logic [3:0]     s_axi_wstrb_i,
	input  wire logic           s_axi_wvalid_i,
	output logic                s_axi_wready_o,
	// AXI4-Lite write response
	output logic [1:0]          s_axi_bresp_o,
	output logic                s_axi_bvalid_o,
	input  wire logic           s_axi_bready_i,
	// AXI4-Lite read
	input  wire logic [7:0]     s_axi_araddr_i,
	input  wire logic           s_axi_arvalid_i,
	output logic                s_axi_arready_o,
	output logic [31:0]         s_axi_rdata_o,
	output logic [1:0]          s_axi_rresp_o,
	output logic                s_axi_rvalid_o,
	input  wire logic           s_axi_rready_i,
	// Clock source strap and two-way clock pin
	input  wire logic           osc_ext_sel_i,
	input  wire logic           clk_pin_i,
	output logic                clk_pin_o,
	output logic                clk_pin_oe_o,
	// Cascade sync line, open drain, active low
	input  wire logic           sync_n_i,
	output logic                sync_n_o,
	output logic                sync_n_oe_o,
	// LCD drive level codes, two bits per pin
	output logic [2*NUM_BP-1:0]  backplane_outputs_o,
	output logic [2*NUM_SEG-1:0] segment_outputs_o
);
	// Synchroniser stages for strap, clock pin and sync line
	logic               osc_s1, osc_s2;
	logic               clk_s1, clk_s2, clk_s3;
	logic               syn_s1, syn_s2, syn_s3;
	// Internal oscillator
	logic [15:0]        osc_cnt, next_osc_cnt;
	logic               osc_lvl, next_osc_lvl;
	logic               osc_wrap, int_rise, ext_rise, tick;
	// Register file
	logic [31:0]        ctrl, next_ctrl;
	logic [31:0]        ram [0:7];
	logic [31:0]        next_ram [0:7];
	// AXI write and read state
	logic               aw_full, next_aw_full, w_full, next_w_full;
	logic [7:0]         aw_addr, next_aw_addr;
	logic [31:0]        w_data, next_w_data;
	logic [3:0]         w_strb, next_w_strb;
	logic               bvalid, next_bvalid, rvalid, next_rvalid;
	logic [1:0]         bresp, next_bresp, rresp, next_rresp;
	logic [31:0]        rdata, next_rdata;
	// Frame timing and active configuration
	logic [4:0]         fcnt, next_fcnt;
	logic [2:0]         slot, next_slot;
	logic [3:0]         stick, next_stick;
	logic               sync_pend, next_sync_pend, sync_fall, frame_load;
	lmd_mode_t          act_mode, next_act_mode;
	logic               act_half, next_act_half, act_en, next_act_en;
	logic [7:0]         frame_cnt, next_frame_cnt;
	logic [3:0][59:0]   disp, next_disp;
	// Drive phase and output stage
	logic [2:0]         nratio;
	logic               pol;
	logic [1:0]         row;
	logic [2*NUM_BP-1:0]  next_bp;
	logic [2*NUM_SEG-1:0] next_seg;
	logic               next_sync_oe;

	// Two-flop synchronisers; clock pin and sync line add a third stage for edge detection
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			{osc_s1, osc_s2}         <= 2'h0;
			{clk_s1, clk_s2, clk_s3} <= 3'h0;
			{syn_s1, syn_s2, syn_s3} <= 3'h7;
		end else begin
			{osc_s1, osc_s2}         <= {osc_ext_sel_i, osc_s1};
			{clk_s1, clk_s2, clk_s3} <= {clk_pin_i, clk_s1, clk_s2};
			{syn_s1, syn_s2, syn_s3} <= {sync_n_i, syn_s1, syn_s2};
		end
	end

	// Internal oscillator runs always so switching straps never stalls the panel
	always_comb begin
		osc_wrap     = (osc_cnt == 16'(OSC_HALF_CYC - 1));
		next_osc_cnt = osc_wrap ? 16'h0000 : osc_cnt + 16'h0001;
		next_osc_lvl = osc_wrap ? !osc_lvl : osc_lvl;
	end
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			osc_cnt <= 16'h0000;
			osc_lvl <= 1'b0;
		end else begin
			osc_cnt <= next_osc_cnt;
			osc_lvl <= next_osc_lvl;
		end
	end
	// Working tick: one rising edge of the selected clock
	assign int_rise     = osc_wrap && !osc_lvl;
	assign ext_rise     = clk_s2 && !clk_s3;
	assign tick         = osc_s2 ? ext_rise : int_rise;
	assign clk_pin_o    = osc_lvl;
	assign clk_pin_oe_o = !osc_s2;

	// Write channel: address and data taken in either order, answered once both held
	always_comb begin
		next_aw_full = aw_full;
		next_aw_addr = aw_addr;
		next_w_full  = w_full;
		next_w_data  = w_data;
		next_w_strb  = w_strb;
		next_bvalid  = bvalid;
		next_bresp   = bresp;
		next_ctrl    = ctrl;
		for (int i = 0; i < 8; i++) begin
			next_ram[i] = ram[i];
		end
		if (s_axi_awvalid_i && s_axi_awready_o) begin
			next_aw_full = 1'b1;
			next_aw_addr = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && s_axi_wready_o) begin
			next_w_full = 1'b1;
			next_w_data = s_axi_wdata_i;
			next_w_strb = s_axi_wstrb_i;
		end
		if (bvalid && s_axi_bready_i) begin
			next_bvalid = 1'b0;
		end
		if (aw_full && w_full && !bvalid) begin
			// Perform the write; strobes gate each byte lane
			next_aw_full = 1'b0;
			next_w_full  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = RESP_OKAY;
			if (aw_addr == CTRL_OFS) begin
				// Mode-set lands here, applied at the next frame start
				for (int b = 0; b < 4; b++) begin
					if (w_strb[b]) next_ctrl[8*b +: 8] = w_data[8*b +: 8] & CTRL_MASK[8*b +: 8];
				end
			end else if (aw_addr >= RAM_OFS && aw_addr <= RAM_END && aw_addr[1:0] == 2'h0) begin
				for (int b = 0; b < 4; b++) begin
					if (w_strb[b]) next_ram[3'(aw_addr[7:2] - 6'h04)][8*b +: 8] = w_data[8*b +: 8];
				end
				if (aw_addr[2]) begin
					next_ram[3'(aw_addr[7:2] - 6'h04)] = next_ram[3'(aw_addr[7:2] - 6'h04)] & RAM_HI_MASK;
				end
			end else if (aw_addr != STAT_OFS) begin
				// Unmapped address; the status word ignores writes
				next_bresp = RESP_SLVERR;
			end
		end
	end
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			aw_full <= 1'b0;
			aw_addr <= 8'h00;
			w_full  <= 1'b0;
			w_data  <= 32'h0000_0000;
			w_strb  <= 4'h0;
			bvalid  <= 1'b0;
			bresp   <= RESP_OKAY;
			ctrl    <= CTRL_RST;
			for (int i = 0; i < 8; i++) begin
				ram[i] <= 32'h0000_0000;
			end
		end else begin
			aw_full <= next_aw_full;
			aw_addr <= next_aw_addr;
			w_full  <= next_w_full;
			w_data  <= next_w_data;
			w_strb  <= next_w_strb;
			bvalid  <= next_bvalid;
			bresp   <= next_bresp;
			ctrl    <= next_ctrl;
			for (int i = 0; i < 8; i++) begin
				ram[i] <= next_ram[i];
			end
		end
	end
	assign s_axi_awready_o = !aw_full && !bvalid;
	assign s_axi_wready_o  = !w_full && !bvalid;
	assign s_axi_bvalid_o  = bvalid;
	assign s_axi_bresp_o   = bresp;

	// Read channel: one read at a time, data registered
	always_comb begin
		next_rvalid = rvalid;
		next_rdata  = rdata;
		next_rresp  = rresp;
		if (rvalid && s_axi_rready_i) begin
			next_rvalid = 1'b0;
		end
		if (s_axi_arvalid_i && !rvalid) begin
			next_rvalid = 1'b1;
			next_rresp  = RESP_OKAY;
			next_rdata  = 32'h0000_0000;
			if (s_axi_araddr_i == CTRL_OFS) begin
				next_rdata = ctrl;
			end else if (s_axi_araddr_i == STAT_OFS) begin
				// Live timing state for software
				next_rdata[7:0] = {act_en, act_half, act_mode, pol, slot};
				next_rdata[STAT_OSC_BIT] = osc_s2;
				next_rdata[STAT_FCNT_LSB +: 8] = frame_cnt;
			end else if (s_axi_araddr_i >= RAM_OFS && s_axi_araddr_i <= RAM_END
				&& s_axi_araddr_i[1:0] == 2'h0) begin
				next_rdata = ram[3'(s_axi_araddr_i[7:2] - 6'h04)];
			end else begin
				next_rresp = RESP_SLVERR;
			end
		end
	end
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rvalid <= 1'b0;
			rdata  <= 32'h0000_0000;
			rresp  <= RESP_OKAY;
		end else begin
			rvalid <= next_rvalid;
			rdata  <= next_rdata;
			rresp  <= next_rresp;
		end
	end
	assign s_axi_arready_o = !rvalid;
	assign s_axi_rvalid_o  = rvalid;
	assign s_axi_rdata_o   = rdata;
	assign s_axi_rresp_o   = rresp;

	// Frame timing: 24 ticks, equal slots, resync on a falling sync line
	// Our own pull must not count as a partner's frame start, or tick 1 reloads the display
	assign sync_fall  = !syn_s2 && syn_s3 && !sync_n_oe_o;
	assign frame_load = tick && (sync_pend || fcnt == FRAME_LAST);
	always_comb begin
		next_fcnt      = fcnt;
		next_slot      = slot;
		next_stick     = stick;
		next_act_mode  = act_mode;
		next_act_half  = act_half;
		next_act_en    = act_en;
		next_frame_cnt = frame_cnt;
		next_disp      = disp;
		// A fall in the consuming cycle is kept, set wins
		next_sync_pend = sync_fall || (sync_pend && !tick);
		if (frame_load) begin
			// Another device started its frame: land on our tick 1 as it does
			next_fcnt      = sync_pend ? 5'h01 : 5'h00;
			next_stick     = sync_pend ? 4'h1 : 4'h0;
			next_slot      = 3'h0;
			next_frame_cnt = frame_cnt + 8'h01;
			// Configuration swaps only at a frame edge so no slot is cut short
			next_act_mode  = lmd_mode_t'(ctrl[CTRL_MODE_LSB +: 2]);
			next_act_half  = ctrl[CTRL_HALF_BIT];
			next_act_en    = ctrl[CTRL_EN_BIT];
			// RAM copied into the display register, row r word pair
			for (int r = 0; r < NUM_BP; r++) begin
				next_disp[r] = {ram[2*r+1][27:0], ram[2*r]};
			end
		end else if (tick) begin
			next_fcnt = fcnt + 5'h01;
			if (stick == lmd_slot_len(act_mode) - 4'h1) begin
				next_stick = 4'h0;
				next_slot  = slot + 3'h1;
			end else begin
				next_stick = stick + 4'h1;
			end
		end
	end
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			fcnt      <= 5'h00;
			slot      <= 3'h0;
			stick     <= 4'h0;
			sync_pend <= 1'b0;
			act_mode  <= LMD_MUX4;
			act_half  <= 1'b1;
			act_en    <= 1'b0;
			frame_cnt <= 8'h00;
			disp      <= '0;
		end else begin
			fcnt      <= next_fcnt;
			slot      <= next_slot;
			stick     <= next_stick;
			sync_pend <= next_sync_pend;
			act_mode  <= next_act_mode;
			act_half  <= next_act_half;
			act_en    <= next_act_en;
			frame_cnt <= next_frame_cnt;
			disp      <= next_disp;
		end
	end

	// Phase: first half-frame positive, second half inverted
	assign nratio = {1'b0, act_mode} + 3'h1;
	assign pol    = (slot >= nratio);
	assign row    = 2'(pol ? slot - nratio : slot);

	// Drive levels: codes mean VSS, 1/3 or 1/2, 2/3, VLCD
	always_comb begin
		logic [1:0] eff;
		eff = 2'h0;
		for (int k = 0; k < NUM_BP; k++) begin
			// Unused backplanes repeat their partner
			case (act_mode)
				LMD_STATIC: eff = 2'h0;
				LMD_MUX2:   eff = {1'b0, k[0]};
				LMD_MUX3:   eff = (k == 3) ? 2'h1 : 2'(k);
				default:    eff = 2'(k);
			endcase
			if (!act_en) begin
				next_bp[2*k +: 2] = LVL_VLCD;
			end else if (eff == row) begin
				next_bp[2*k +: 2] = pol ? LVL_VSS : LVL_VLCD;
			end else if (act_half) begin
				next_bp[2*k +: 2] = LVL_HALF;
			end else begin
				next_bp[2*k +: 2] = pol ? LVL_TWO3 : LVL_THIRD;
			end
		end
		for (int c = 0; c < NUM_SEG; c++) begin
			if (!act_en) begin
				next_seg[2*c +: 2] = LVL_VLCD;
			end else if (disp[row][c]) begin
				// Opposite extreme to the selected backplane
				next_seg[2*c +: 2] = pol ? LVL_VLCD : LVL_VSS;
			end else if (act_half || act_mode == LMD_STATIC) begin
				next_seg[2*c +: 2] = pol ? LVL_VSS : LVL_VLCD;
			end else begin
				next_seg[2*c +: 2] = pol ? LVL_THIRD : LVL_TWO3;
			end
		end
		// Pull sync low through tick 0 of each frame
		next_sync_oe = (fcnt == 5'h00);
	end
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			backplane_outputs_o <= {NUM_BP{LVL_VLCD}};
			segment_outputs_o   <= {NUM_SEG{LVL_VLCD}};
			sync_n_oe_o         <= 1'b0;
		end else begin
			backplane_outputs_o <= next_bp;
			segment_outputs_o   <= next_seg;
			sync_n_oe_o         <= next_sync_oe;
		end
	end
	assign sync_n_o = 1'b0;

	// Checks on the drive behaviour
	off_all_vlcd_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
		!act_en |=> (&backplane_outputs_o) && (&segment_outputs_o))
		else $error("disabled display not at LCD supply");
	static_bp_same_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
		act_mode == LMD_STATIC |=> backplane_outputs_o == {4{backplane_outputs_o[1:0]}})
		else $error("static backplanes differ");
	mux2_pairs_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
		act_mode == LMD_MUX2 |=> backplane_outputs_o[3:0] == backplane_outputs_o[7:4])
		else $error("1:2 backplane pairs differ");
	mux3_mirror_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
		act_mode == LMD_MUX3 |=> backplane_outputs_o[7:6] == backplane_outputs_o[3:2])
		else $error("1:3 fourth backplane not mirroring second");
	frame_wrap_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
		tick && fcnt == 5'h17 && !sync_pend |=> fcnt == 5'h00 && slot == 3'h0)
		else $error("frame not 24 ticks");
	sync_align_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
		tick && sync_pend |=> fcnt == 5'h01 && stick == 4'h1)
		else $error("sync did not realign frame");
	clk_out_edge_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
		!osc_s1 && !osc_s2 && int_rise |=> clk_pin_o && clk_pin_oe_o)
		else $error("internal clock not driven out");
	disp_hold_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
		!frame_load |=> $stable(disp))
		else $error("display register changed mid frame");
	cfg_apply_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
		frame_load |=> act_mode == lmd_mode_t'($past(ctrl[2:1])) && act_en == $past(ctrl[0]))
		else $error("mode-set not applied at frame start");
	third_unsel_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
		act_en && !act_half && act_mode == LMD_MUX4 && row != 2'h0
		|=> backplane_outputs_o[1:0] == ($past(pol) ? LVL_TWO3 : LVL_THIRD))
		else $error("third bias unselected level wrong");
	pol_invert_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
		act_en && act_mode == LMD_STATIC && pol |=> backplane_outputs_o[1:0] == LVL_VSS)
		else $error("second half-frame not inverted");
endmodule

// ---- testbench/lmd_panel.sv ----
// LCD panel load model that integrates the net drive seen by one display element
module lmd_panel
	import lmd_pkg::*;
(
	// Clock
	input  wire logic                 clock_i,
	// Bias the panel is driven with: level code 1 is a half, else a third
	input  wire logic                 half_i,
	// Drive level codes from the block
	input  wire logic [2*NUM_BP-1:0]  bp_i,
	input  wire logic [2*NUM_SEG-1:0] seg_i,
	// Running sum of backplane level minus segment level
	output int                        dc_sum_o
);
	timeunit 1ns;
	timeprecision 100ps;

	int acc = 0;    // Net drive in sixths of the supply, one sample per clock

	// Level code as sixths of the supply, so half and third bias weigh alike
	function automatic int sixths(input logic [1:0] lvl, input logic half);
		return (lvl == 2'h1 && half) ? 3 : 2 * int'(lvl);
	endfunction

	// Element on backplane 1 and segment 40: its data never changes during the run
	// The liquid crystal is harmed by any net DC, so one frame must sum to zero
	always @(posedge clock_i) begin
		acc <= acc + sixths(bp_i[3:2], half_i) - sixths(seg_i[81:80], half_i);
	end
	assign dc_sum_o = acc;
endmodule

// ---- testbench/lmd_drive_tb_top.sv ----
// Self-checking bench for the LCD multiplex drive timing block
module lmd_drive_tb_top
	import lmd_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int unsigned OSC_H   = 4;         // Short oscillator half period
	localparam int          TICK_NS = 16 * OSC_H; // Working tick in ns
	localparam int          EXT_NS  = 106;       // External clock period, not a clock multiple

	// Bench-driven inputs, all valued at time zero
	logic        clock_i = 1'b0, arst_n_i = 1'b0, osc_ext_sel_i = 1'b0;
	logic [7:0]  s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
	logic [31:0] s_axi_wdata_i = 32'h0;
	logic [3:0]  s_axi_wstrb_i = 4'hF;
	logic        s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
	logic        s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
	logic        ext_clk = 1'b0, ext_sync_n = 1'b1; // Cascade partner clock and sync pull
	logic        half_on = 1'b0;                    // Bias the panel model weighs levels with
	// Design outputs
	logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
	logic        s_axi_rvalid_o, clk_pin_o, clk_pin_oe_o, sync_n_o, sync_n_oe_o;
	logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
	logic [31:0] s_axi_rdata_o;
	logic [7:0]  backplane_outputs_o;
	logic [119:0] segment_outputs_o;
	// Resolved pins: clock pin from whoever drives it, sync is open drain with pull-up
	wire logic   clk_pin_i = clk_pin_oe_o ? clk_pin_o : ext_clk;
	wire logic   sync_n_i  = (sync_n_oe_o ? sync_n_o : 1'b1) & ext_sync_n;
	int          n_mismatch = 0, total_checks = 0, dc_sum;
	logic [31:0] row0 = 32'hAAAA_AAAA;  // Current row 0 low word in the display
	logic [31:0] pat [4] = '{32'hAAAA_AAAA, 32'hCCCC_CCCC, 32'hF0F0_F0F0, 32'hFF00_FF00};

	lmd_drive #(.OSC_HALF_CYC(OSC_H)) DUT (.clock_i, .arst_n_i, .s_axi_awaddr_i,
		.s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i,
		.s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i,
		.s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
		.s_axi_rready_i, .osc_ext_sel_i, .clk_pin_i, .clk_pin_o, .clk_pin_oe_o, .sync_n_i,
		.sync_n_o, .sync_n_oe_o, .backplane_outputs_o, .segment_outputs_o);
	lmd_panel PANEL (.clock_i(clock_i), .half_i(half_on), .bp_i(backplane_outputs_o),
		.seg_i(segment_outputs_o), .dc_sum_o(dc_sum));

	// System clock, 8 ns period
	initial forever #4 clock_i = ~clock_i;
	// External working clock: runs only while the strap selects it, never stops then
	initial forever begin
		#(EXT_NS / 2);
		if (osc_ext_sel_i) ext_clk = ~ext_clk;
	end

	// Compare and count, report a mismatch at once
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// AXI4-Lite write: address and data offered together, each released when taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		bit aw, w;
		aw = 0;
		w = 0;
		@(posedge clock_i);
		s_axi_awaddr_i  <= a;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wdata_i   <= d;
		s_axi_wvalid_i  <= 1'b1;
		s_axi_bready_i  <= 1'b1;
		while (!(aw && w)) begin
			@(posedge clock_i);
			if (!aw && s_axi_awready_o === 1'b1) begin
				aw = 1;
				s_axi_awvalid_i <= 1'b0;
			end
			if (!w && s_axi_wready_o === 1'b1) begin
				w = 1;
				s_axi_wvalid_i <= 1'b0;
			end
		end
		while (s_axi_bvalid_o !== 1'b1) @(posedge clock_i);
		r = s_axi_bresp_o;
		s_axi_bready_i <= 1'b0;
	endtask

	// AXI4-Lite read: hold request until taken, hold rready until the answer
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clock_i);
		s_axi_araddr_i  <= a;
		s_axi_arvalid_i <= 1'b1;
		s_axi_rready_i  <= 1'b1;
		do @(posedge clock_i); while (s_axi_arready_o !== 1'b1);
		s_axi_arvalid_i <= 1'b0;
		do @(posedge clock_i); while (s_axi_rvalid_o !== 1'b1);
		d = s_axi_rdata_o;
		r = s_axi_rresp_o;
		s_axi_rready_i <= 1'b0;
	endtask

	task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic [1:0] r;
		axi_wr(a, d, r);
		chk("bresp", 32'(r), 32'(er));
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0]  r;
		axi_rd(a, d, r);
		chk("rdata", d, ed);
		chk("rresp", 32'(r), 32'(er));
	endtask

	// Expected backplane code; mirrors map unused pins onto active ones
	function automatic logic [1:0] exp_bp(input int n, input bit h, input int k, input int s);
		int lg;
		lg = (n == 3 && k == 3) ? 1 : k % n;
		if (lg == s % n) return (s >= n) ? LVL_VSS : LVL_VLCD;
		return (h || s < n) ? LVL_HALF : LVL_TWO3;
	endfunction

	// Expected segment code: on is opposite the selected backplane
	function automatic logic [1:0] exp_seg(input int n, input bit h, input int s, input bit on);
		if (on) return (s >= n) ? LVL_VLCD : LVL_VSS;
		if (n == 1 || h) return (s >= n) ? LVL_VSS : LVL_VLCD;
		return (s >= n) ? LVL_THIRD : LVL_TWO3;
	endfunction

	// Reset values, then a display left disabled for two frames
	task automatic t_reset;
		logic [31:0] d;
		logic [1:0]  r;
		chk("bp_rst", 32'(backplane_outputs_o), 32'({NUM_BP{LVL_VLCD}}));
		chk("seg_rst", 32'(segment_outputs_o === {NUM_SEG{LVL_VLCD}}), 32'h1);
		@(posedge clock_i);
		arst_n_i <= 1'b1;
		repeat (48 * 2 * OSC_H) @(posedge clock_i);
		chk("seg_off", 32'(segment_outputs_o === {NUM_SEG{LVL_VLCD}}), 32'h1);
		rd_chk(CTRL_OFS, CTRL_RST, RESP_OKAY);
		// Active config after two frames: 1:4, half bias, off, internal clock
		axi_rd(STAT_OFS, d, r);
		chk("stat_cfg", 32'(d[8:4]), 32'h0000_0007);
		chk("stat_resp", 32'(r), 32'(RESP_OKAY));
	endtask

	// Register access, masked RAM words, refused addresses
	task automatic t_regs;
		for (int r = 0; r < 4; r++) begin
			wr_chk(RAM_OFS + 8'(8 * r), pat[r], RESP_OKAY);
			wr_chk(RAM_OFS + 8'(8 * r + 4), pat[r], RESP_OKAY);
			rd_chk(RAM_OFS + 8'(8 * r + 4), pat[r] & RAM_HI_MASK, RESP_OKAY);
		end
		wr_chk(8'h08, 32'h0000_0001, RESP_SLVERR);
		rd_chk(8'h08, 32'h0000_0000, RESP_SLVERR);
		wr_chk(STAT_OFS, 32'hFFFF_FFFF, RESP_OKAY);
		wr_chk(CTRL_OFS, 32'hFFFF_FFF6, RESP_OKAY);
		rd_chk(CTRL_OFS, 32'h0000_0006, RESP_OKAY);
	endtask

	// Frame length, sync pulse width and clock pin rate, within a tolerance in ns
	task automatic meas(input int tick, input int tol, input logic oe);
		int t0, d;
		@(posedge sync_n_oe_o);
		t0 = int'($time);
		@(negedge sync_n_oe_o);
		d = int'($time) - t0;
		chk("sync_width", 32'(d >= tick - tol && d <= tick + tol), 32'h1);
		@(posedge sync_n_oe_o);
		d = int'($time) - t0;
		chk("frame_len", 32'(d >= 24 * tick - tol && d <= 24 * tick + tol), 32'h1);
		@(posedge clk_pin_i);
		t0 = int'($time);
		@(posedge clk_pin_i);
		d = int'($time) - t0;
		chk("clk_pin", 32'(d >= tick - tol && d <= tick + tol), 32'h1);
		chk("clk_oe", 32'(clk_pin_oe_o), 32'(oe));
		chk("sync_lvl", 32'(sync_n_o), 32'h0);
	endtask

	// One mode: apply config, change row 0 mid-frame, check ticks 4 to 23 of that frame
	task automatic scan(input int n, input bit h, input logic [31:0] nrow0);
		logic [1:0] r, e;
		int t0, s, dc0, row;
		bit on;
		axi_wr(CTRL_OFS, (32'(h) << CTRL_HALF_BIT) | (32'(n - 1) << CTRL_MODE_LSB) | 32'h1, r);
		half_on <= h;
		@(posedge sync_n_oe_o);
		@(posedge sync_n_oe_o);
		t0 = int'($time);
		dc0 = dc_sum;
		axi_wr(RAM_OFS, nrow0, r);
		for (int t = 4; t < 24; t++) begin
			#(t0 + t * TICK_NS + 36 - int'($time));
			s = t / (12 / n);
			row = s % n;
			for (int k = 0; k < 4; k++) begin
				e = exp_bp(n, h, k, s);
				chk("bp", 32'(backplane_outputs_o[2*k +: 2]), 32'(e));
			end
			for (int c = 0; c < 60; c++) begin
				on = (row == 0 && c < 32) ? row0[c] : c[row];
				e = exp_seg(n, h, s, on);
				chk("seg", 32'(segment_outputs_o[2*c +: 2]), 32'(e));
			end
		end
		@(posedge sync_n_oe_o);
		chk("dc_net", 32'(dc_sum - dc0), 32'h0);
		row0 = nrow0;
	endtask

	// Cascade partner pulls sync mid-frame: frame restarts from it
	task automatic t_sync;
		int t0, d;
		@(posedge sync_n_oe_o);
		repeat (20 * OSC_H) @(posedge clock_i);
		ext_sync_n <= 1'b0;
		t0 = int'($time);
		repeat (4) @(posedge clock_i);
		ext_sync_n <= 1'b1;
		@(posedge sync_n_oe_o);
		d = int'($time) - t0;
		chk("resync", 32'(d >= 23 * TICK_NS && d <= 24 * TICK_NS + 32), 32'h1);
	endtask

	task automatic final_report;
		$display("Checks made %0d, mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	// Main sequence: reset held 6 cycles, then each scenario in turn
	initial begin
		repeat (5) @(posedge clock_i);
		t_reset();
		t_regs();
		meas(TICK_NS, 0, 1'b1);
		for (int n = 1; n < 5; n++)
			for (int h = 0; h < 2; h++) scan(n, h[0], row0 ^ 32'h0F0F_1234);
		t_sync();
		@(posedge clock_i);
		osc_ext_sel_i <= 1'b1;
		repeat (2) @(posedge sync_n_oe_o);
		meas(EXT_NS, 16, 1'b0);
		final_report();
	end

	// Watchdog: the run needs about 7,000 cycles, give it well over twice that
	initial begin
		#300_000;
		n_mismatch++;
		final_report();
	end
endmodule
